// *** smp_pkg.sv ***
// Purpose: shared constants, states and helpers of the serial memory port
// Assumes: 20 MHz system clock on both ends
// Notes:   both ends and the bench import this package whole

package smp_pkg;

	// ===========================================================
	// command codes and frame sizes
	localparam logic [7:0] CMD_WRITE     = 8'h02;
	localparam logic [7:0] CMD_READ      = 8'h03;
	localparam logic [3:0] CMD_LAST_BIT  = 4'h7;   // index of last command bit
	localparam logic [3:0] WORD_LAST_BIT = 4'hF;   // index of last word bit
	localparam logic [1:0] RESET_SCLK_CYCLES = 2'h2;

	// ===========================================================
	// timing of the serial clock made by the master end
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCLK_HALF_NS  = 500;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

	// ===========================================================
	// buffering and reset values
	localparam int FIFO_DEPTH = 16;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	// ===========================================================
	// state encodings
	typedef enum logic [5:0] {
		DS_IDLE   = 6'h01,
		DS_CMD    = 6'h02,
		DS_ADDR   = 6'h04,
		DS_WDATA  = 6'h08,
		DS_READ   = 6'h10,
		DS_IGNORE = 6'h20
	} smp_dev_state_e;

	typedef enum logic [5:0] {
		HS_IDLE = 6'h01,
		HS_RST  = 6'h02,
		HS_LOW  = 6'h04,
		HS_HIGH = 6'h08,
		HS_LOAD = 6'h10,
		HS_END  = 6'h20
	} smp_host_state_e;

	typedef enum logic [2:0] {
		PH_CMD  = 3'h1,
		PH_ADDR = 3'h2,
		PH_DATA = 3'h4
	} smp_phase_e;

	// ===========================================================
	// shift one bit into a word, msb first
	function automatic logic [15:0] smp_shift_in(input logic [15:0] word, input logic bitIn);
		return {word[14:0], bitIn};
	endfunction

endpackage

// *** smp_if.sv ***
// Purpose: four-wire link between master end and memory port end
// Assumes: plain push-pull wires, master makes the serial clock
// Notes:   no clocking block; both ends sample through their own flops

interface smp_if;

	// ===========================================================
	// link wires
	logic portSelectN;
	logic sclk;
	logic mosi;
	logic miso;

	modport device (
		input  portSelectN,
		input  sclk,
		input  mosi,
		output miso
	);

	modport master (
		output portSelectN,
		output sclk,
		output mosi,
		input  miso
	);

endinterface

// *** smp_fifo.sv ***
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   inReady is registered; outData shows the head word

module smp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0]   count;
		logic          ready;
	} smp_fifo_s;

	smp_fifo_s        r_reg;
	smp_fifo_s        r_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// ===========================================================
	// handshakes on both sides
	assign push     = inValid & r_reg.ready;
	assign pop      = outValid & outReady;
	assign outValid = (r_reg.count != '0);
	assign outData  = mem[r_reg.rdPtr];
	assign inReady  = r_reg.ready;

	// pointer and level update
	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.wrPtr = r_reg.wrPtr + 1'b1;
		end
		if (pop) begin
			r_next.rdPtr = r_reg.rdPtr + 1'b1;
		end
		r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
		r_next.ready = (r_next.count != (AW+1)'(DEPTH));
	end

	// state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1};
		end else begin
			r_reg <= r_next;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[r_reg.wrPtr] <= inData;
		end
	end

endmodule

// *** smp_device.sv ***
// Purpose: serial slave port giving an outside master word access to memory
// Assumes: link wires are asynchronous to clk; memory answers reads with memAck
// Notes:   every link input passes two flops; edges of sclk found on clk

module smp_device
	import smp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	smp_if.device            link,
	input  wire logic        procRunning,
	output logic             memReq,
	output logic             memWe,
	output logic [15:0]      memAddr,
	output logic [15:0]      memWdata,
	input  wire logic        memAck,
	input  wire logic [15:0] memRdata,
	output logic             txnActive,
	output logic             cmdRejected,
	output logic             wordAborted
);

	typedef struct packed {
		smp_dev_state_e state;
		logic [1:0]     selSy;
		logic [1:0]     clkSy;
		logic [1:0]     mosiSy;
		logic           clkPrev;
		logic [1:0]     rstEdges;
		logic           armed;
		logic [3:0]     bitCnt;
		logic [15:0]    inSh;
		logic [15:0]    outSh;
		logic [15:0]    addr;
		logic [15:0]    rdBuf;
		logic [7:0]     cmd;
		logic           miso;
		logic           memReq;
		logic           memWe;
		logic [15:0]    memAddr;
		logic [15:0]    memWdata;
		logic           txnActive;
		logic           cmdRejected;
		logic           wordAborted;
	} smp_dev_s;

	smp_dev_s    r_reg;
	smp_dev_s    r_next;
	logic        selHigh;
	logic        sclkRise;
	logic        sclkFall;
	logic        mosiBit;
	logic [15:0] wordIn;

	// ===========================================================
	// synchronised link view
	assign selHigh  = r_reg.selSy[1];
	assign mosiBit  = r_reg.mosiSy[1];
	assign sclkRise = r_reg.clkSy[1] & ~r_reg.clkPrev;
	assign sclkFall = ~r_reg.clkSy[1] & r_reg.clkPrev;
	assign wordIn   = smp_shift_in(r_reg.inSh, mosiBit);

	// ===========================================================
	// outputs straight from the state flops
	assign link.miso   = r_reg.miso;
	assign memReq      = r_reg.memReq;
	assign memWe       = r_reg.memWe;
	assign memAddr     = r_reg.memAddr;
	assign memWdata    = r_reg.memWdata;
	assign txnActive   = r_reg.txnActive;
	assign cmdRejected = r_reg.cmdRejected;
	assign wordAborted = r_reg.wordAborted;

	// ===========================================================
	// next-state logic
	always_comb begin
		r_next             = r_reg;
		r_next.memReq      = 1'b0;
		r_next.memWe       = 1'b0;
		r_next.cmdRejected = 1'b0;
		r_next.wordAborted = 1'b0;

		// two-flop synchronisers; clkSy[1] is the serial clock seen by all logic
		r_next.selSy   = {r_reg.selSy[0], link.portSelectN};
		r_next.clkSy   = {r_reg.clkSy[0], link.sclk};
		r_next.mosiSy  = {r_reg.mosiSy[0], link.mosi};
		r_next.clkPrev = r_reg.clkSy[1];

		// read answers are caught whenever they arrive
		if (memAck) begin
			r_next.rdBuf = memRdata;
		end

		if (selHigh) begin
			// deselected: drive the idle level, never float
			r_next.miso      = ~procRunning;
			r_next.state     = DS_IDLE;
			r_next.txnActive = 1'b0;
			r_next.bitCnt    = 4'h0;
			// a partial word at termination is dropped and flagged
			if (r_reg.state != DS_IDLE && r_reg.state != DS_IGNORE && r_reg.bitCnt != 4'h0) begin
				r_next.wordAborted = 1'b1;
			end
			// count serial clocks while high to arm the port
			if (sclkRise && r_reg.rstEdges != RESET_SCLK_CYCLES) begin
				r_next.rstEdges = r_reg.rstEdges + 2'h1;
			end
			if (r_next.rstEdges == RESET_SCLK_CYCLES) begin
				r_next.armed = 1'b1;
			end
		end else begin
			case (r_reg.state)
				DS_IDLE: begin
					// select just fell: start only if the port was reset first
					r_next.rstEdges  = 2'h0;
					r_next.armed     = 1'b0;
					r_next.txnActive = r_reg.armed;
					r_next.state     = r_reg.armed ? DS_CMD : DS_IGNORE;
				end
				DS_CMD: begin
					if (sclkRise) begin
						r_next.inSh   = wordIn;
						r_next.bitCnt = r_reg.bitCnt + 4'h1;
						if (r_reg.bitCnt == CMD_LAST_BIT) begin
							r_next.cmd    = wordIn[7:0];
							r_next.bitCnt = 4'h0;
							r_next.state  = DS_ADDR;
						end
					end
				end
				DS_ADDR: begin
					if (sclkRise) begin
						r_next.inSh   = wordIn;
						r_next.bitCnt = r_reg.bitCnt + 4'h1;
						if (r_reg.bitCnt == WORD_LAST_BIT) begin
							r_next.addr = wordIn;
							if (r_reg.cmd == CMD_WRITE) begin
								r_next.state = DS_WDATA;
							end else if (r_reg.cmd == CMD_READ) begin
								// check word goes out first, data fetched meanwhile
								r_next.state    = DS_READ;
								r_next.outSh    = {r_reg.cmd, wordIn[15:8]};
								r_next.memReq   = 1'b1;
								r_next.memAddr  = wordIn;
							end else begin
								r_next.state       = DS_IGNORE;
								r_next.cmdRejected = 1'b1;
							end
						end
					end
				end
				DS_WDATA: begin
					if (sclkRise) begin
						r_next.inSh   = wordIn;
						r_next.bitCnt = r_reg.bitCnt + 4'h1;
						if (r_reg.bitCnt == WORD_LAST_BIT) begin
							// store the full word, then step to the next location
							r_next.memReq   = 1'b1;
							r_next.memWe    = 1'b1;
							r_next.memAddr  = r_reg.addr;
							r_next.memWdata = wordIn;
							r_next.addr     = r_reg.addr + 16'h0001;
						end
					end
				end
				DS_READ: begin
					if (sclkFall) begin
						r_next.miso  = r_reg.outSh[15];
						r_next.outSh = {r_reg.outSh[14:0], 1'b0};
					end
					if (sclkRise) begin
						r_next.bitCnt = r_reg.bitCnt + 4'h1;
						if (r_reg.bitCnt == WORD_LAST_BIT) begin
							// next word comes from the prefetch; fetch the one after
							r_next.outSh   = r_reg.rdBuf;
							r_next.addr    = r_reg.addr + 16'h0001;
							r_next.memReq  = 1'b1;
							r_next.memAddr = r_reg.addr + 16'h0001;
						end
					end
				end
				DS_IGNORE: begin
					// hold output, touch no memory until select rises
					r_next.miso = r_reg.miso;
				end
				default: begin
					r_next.state = DS_IDLE;
				end
			endcase
		end
	end

	// ===========================================================
	// state register; procRunning only steers the idle level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{
				state: DS_IDLE, selSy: 2'h3, clkSy: 2'h0, mosiSy: 2'h0,
				clkPrev: 1'b0, rstEdges: 2'h0, armed: 1'b0, bitCnt: 4'h0,
				inSh: WORD_ZERO, outSh: WORD_ZERO, addr: WORD_ZERO, rdBuf: WORD_ZERO,
				cmd: 8'h00, miso: 1'b0, memReq: 1'b0, memWe: 1'b0,
				memAddr: WORD_ZERO, memWdata: WORD_ZERO, txnActive: 1'b0,
				cmdRejected: 1'b0, wordAborted: 1'b0
			};
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

// *** smp_host.sv ***
// Purpose: master end that runs reset, command, address and data words
// Assumes: write words are queued in the fifo before or during a write
// Notes:   serial clock stalls low while the fifo is empty

module smp_host
	import smp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	smp_if.master            link,
	input  wire logic        start,
	input  wire logic [7:0]  startCmd,
	input  wire logic [15:0] startAddr,
	input  wire logic [15:0] startWords,
	input  wire logic [15:0] wrData,
	input  wire logic        wrValid,
	output logic             wrReady,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdData,
	output logic             rdValid,
	output logic             rdCheck
);

	typedef struct packed {
		smp_host_state_e state;
		smp_phase_e      phase;
		logic [1:0]      misoSy;
		logic [3:0]      tick;
		logic [1:0]      edges;
		logic [3:0]      bitCnt;
		logic [15:0]     wordsLeft;
		logic            readMode;
		logic            firstWord;
		logic [15:0]     txSh;
		logic [15:0]     rxSh;
		logic [15:0]     addr;
		logic            sclk;
		logic            csn;
		logic            mosi;
		logic            busy;
		logic            done;
		logic [15:0]     rdData;
		logic            rdValid;
		logic            rdCheck;
	} smp_host_s;

	smp_host_s   r_reg;
	smp_host_s   r_next;
	logic [15:0] fifoData;
	logic        fifoValid;
	logic        halfDone;

	// ===========================================================
	// write word buffer
	smp_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.inData   (wrData),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (r_reg.state == HS_LOAD)
	);

	assign halfDone         = (r_reg.tick == SCLK_HALF_LAST);
	assign link.portSelectN = r_reg.csn;
	assign link.sclk        = r_reg.sclk;
	assign link.mosi        = r_reg.mosi;
	assign busy             = r_reg.busy;
	assign done             = r_reg.done;
	assign rdData           = r_reg.rdData;
	assign rdValid          = r_reg.rdValid;
	assign rdCheck          = r_reg.rdCheck;

	// ===========================================================
	// sequencer
	always_comb begin
		r_next         = r_reg;
		r_next.done    = 1'b0;
		r_next.rdValid = 1'b0;
		r_next.misoSy  = {r_reg.misoSy[0], link.miso};
		r_next.tick    = halfDone ? 4'h0 : r_reg.tick + 4'h1;
		case (r_reg.state)
			HS_IDLE: begin
				r_next.tick = 4'h0;
				if (start) begin
					r_next.busy      = 1'b1;
					r_next.edges     = 2'h0;
					r_next.readMode  = (startCmd == CMD_READ);
					r_next.txSh      = {startCmd, 8'h00};
					r_next.addr      = startAddr;
					r_next.wordsLeft = startWords;
					r_next.state     = HS_RST;
				end
			end
			HS_RST: begin
				// toggle the clock with select high to reset the port
				if (halfDone) begin
					r_next.sclk = ~r_reg.sclk;
					if (!r_reg.sclk) begin
						r_next.edges = r_reg.edges + 2'h1;
					end else if (r_reg.edges == RESET_SCLK_CYCLES) begin
						r_next.csn    = 1'b0;
						r_next.phase  = PH_CMD;
						r_next.bitCnt = CMD_LAST_BIT;
						r_next.state  = HS_LOW;
					end
				end
			end
			HS_LOW: begin
				r_next.mosi = r_reg.txSh[15];
				if (halfDone) begin
					r_next.sclk  = 1'b1;
					r_next.rxSh  = smp_shift_in(r_reg.rxSh, r_reg.misoSy[1]);
					r_next.state = HS_HIGH;
				end
			end
			HS_HIGH: begin
				if (halfDone) begin
					r_next.sclk   = 1'b0;
					r_next.txSh   = {r_reg.txSh[14:0], 1'b0};
					r_next.bitCnt = r_reg.bitCnt - 4'h1;
					r_next.state  = HS_LOW;
					if (r_reg.bitCnt == 4'h0) begin
						r_next.bitCnt = WORD_LAST_BIT;
						case (r_reg.phase)
							PH_CMD: begin
								r_next.txSh  = r_reg.addr;
								r_next.phase = PH_ADDR;
							end
							PH_ADDR: begin
								r_next.phase     = PH_DATA;
								r_next.txSh      = WORD_ZERO;
								r_next.firstWord = 1'b1;
								if (!r_reg.readMode) begin
									r_next.state = (r_reg.wordsLeft == WORD_ZERO) ? HS_END : HS_LOAD;
								end
							end
							default: begin
								if (r_reg.readMode) begin
									// first word back is the check word
									r_next.rdValid   = 1'b1;
									r_next.rdData    = r_reg.rxSh;
									r_next.rdCheck   = r_reg.firstWord;
									r_next.firstWord = 1'b0;
									if (!r_reg.firstWord) begin
										r_next.wordsLeft = r_reg.wordsLeft - 16'h0001;
									end
									if (r_next.wordsLeft == WORD_ZERO && !(r_reg.firstWord && r_reg.wordsLeft != WORD_ZERO)) begin
										r_next.state = HS_END;
									end
								end else begin
									r_next.wordsLeft = r_reg.wordsLeft - 16'h0001;
									r_next.state     = (r_reg.wordsLeft == 16'h0001) ? HS_END : HS_LOAD;
								end
							end
						endcase
					end
				end
			end
			HS_LOAD: begin
				// clock stays low until a write word is available
				r_next.tick = 4'h0;
				if (fifoValid) begin
					r_next.txSh  = fifoData;
					r_next.state = HS_LOW;
				end
			end
			HS_END: begin
				if (halfDone) begin
					r_next.csn   = 1'b1;
					r_next.busy  = 1'b0;
					r_next.done  = 1'b1;
					r_next.state = HS_IDLE;
				end
			end
			default: begin
				r_next.state = HS_IDLE;
			end
		endcase
	end

	// ===========================================================
	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{
				state: HS_IDLE, phase: PH_CMD, misoSy: 2'h0, tick: 4'h0, edges: 2'h0,
				bitCnt: 4'h0, wordsLeft: WORD_ZERO, readMode: 1'b0, firstWord: 1'b0,
				txSh: WORD_ZERO, rxSh: WORD_ZERO, addr: WORD_ZERO, sclk: 1'b0,
				csn: 1'b1, mosi: 1'b0, busy: 1'b0, done: 1'b0, rdData: WORD_ZERO,
				rdValid: 1'b0, rdCheck: 1'b0
			};
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

// *** smp_assertions.sv ***
// Purpose: wire-level checks of the serial memory port link
// Assumes: both link ends run on the same clk and rst
// Notes:   instantiated beside the link interface in tb_top

module smp_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic portSelectN,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic procRunning
);
	timeunit 1ns;
	timeprecision 1ns;

	// ===========================================================
	// helper counters of serial clock rises
	logic       sclkPrev;
	logic [2:0] rstRises;
	logic [9:0] frameRises;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// count rises while deselected and while selected
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclkPrev <= 1'b0;
			rstRises <= 3'h0;
			frameRises <= 10'h000;
		end else begin
			sclkPrev <= sclk;
			if (!portSelectN) begin
				rstRises <= 3'h0;
				if (sclk && !sclkPrev) begin
					frameRises <= frameRises + 10'h001;
				end
			end else begin
				frameRises <= 10'h000;
				if (sclk && !sclkPrev && rstRises != 3'h7) begin
					rstRises <= rstRises + 3'h1;
				end
			end
		end
	end

	// ===========================================================
	// link rules
	AST_IDLE_MISO: assert property ((portSelectN && $stable(procRunning))[*6] |-> miso == !procRunning)
		else $error("idle miso level wrong");
	AST_IDLE_AFTER_END: assert property ($rose(portSelectN) |-> ##[1:6] (miso == !procRunning))
		else $error("miso not back at idle level after frame");
	AST_MISO_ON_FALL: assert property ((!portSelectN && sclk && $past(sclk, 5) && !$past(portSelectN, 5))
		|-> $stable(miso))
		else $error("miso changed late in high phase");
	AST_RESET_MIN: assert property ($fell(portSelectN) |-> rstRises >= 3'h2)
		else $error("frame began without two reset clocks");
	AST_RESET_MAX: assert property (portSelectN |-> rstRises <= 3'h2)
		else $error("serial clock ran outside a frame");
	AST_FRAME_BITS: assert property ($rose(portSelectN)
		|-> frameRises >= 10'h018 && frameRises[3:0] == 4'h8)
		else $error("frame not cmd, addr and whole words");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk ##1 sclk ##1 !sclk)
		else $error("serial clock high time wrong");
	AST_MOSI_STABLE: assert property ((sclk && !portSelectN) |-> $stable(mosi))
		else $error("mosi moved while serial clock high");

endmodule

// *** tb_top.sv ***
// Purpose: end-to-end bench of master end, memory port end and fifo
// Assumes: memory model answers reads one clock after request
// Notes:   memory indexed by the low address byte

module tb_top
	import smp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ===========================================================
	// stimulus and observed signals
	logic        clk = 1'b0, rst = 1'b1, procRunning = 1'b1, start = 1'b0;
	logic        wrValid = 1'b0, memAck = 1'b0;
	logic [7:0]  startCmd = 8'h00;
	logic [15:0] startAddr = 16'h0000, startWords = 16'h0000, wrData = 16'h0000, memRdata = 16'h0000;
	logic        wrReady, busy, done, rdValid, rdCheck, memReq, memWe, txnActive, cmdRejected, wordAborted;
	logic [15:0] rdData, memAddr, memWdata;
	logic [15:0] mem [256];
	logic [16:0] rdQ [$];
	int          n_errors = 0, cmp_count = 0, nRej = 0, nWr = 0, nAbort = 0, k;

	smp_if link ();

	smp_host i_smp_host (.clk(clk), .rst(rst), .link(link), .start(start), .startCmd(startCmd),
		.startAddr(startAddr), .startWords(startWords), .wrData(wrData), .wrValid(wrValid),
		.wrReady(wrReady), .busy(busy), .done(done), .rdData(rdData), .rdValid(rdValid), .rdCheck(rdCheck));

	smp_device i_smp_device (.clk(clk), .rst(rst), .link(link), .procRunning(procRunning),
		.memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
		.memRdata(memRdata), .txnActive(txnActive), .cmdRejected(cmdRejected), .wordAborted(wordAborted));

	smp_assertions i_smp_assertions (.clk(clk), .rst(rst), .portSelectN(link.portSelectN),
		.sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .procRunning(procRunning));

	// clock
	always #25 clk = ~clk;

	// memory model, read capture and pulse counts, all on the falling edge
	always @(negedge clk) begin
		memAck <= 1'b0;
		if (memReq === 1'b1 && memWe === 1'b1) begin
			mem[memAddr[7:0]] <= memWdata;
			nWr <= nWr + 1;
		end else if (memReq === 1'b1) begin
			memAck <= 1'b1;
			memRdata <= mem[memAddr[7:0]];
		end
		if (rdValid === 1'b1) begin
			rdQ.push_back({rdCheck, rdData});
		end
		if (cmdRejected === 1'b1) begin
			nRej <= nRej + 1;
		end
		if (wordAborted === 1'b1) begin
			nAbort <= nAbort + 1;
		end
	end

	// ===========================================================
	// tasks
	task summarize;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task hang;
		n_errors++;
		$display("ERROR %0t wait ran out", $time);
		summarize();
	endtask

	task cmp16(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task cmpCnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			n_errors++;
			$display("ERROR %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	// one transfer through the master end, entered at a falling edge
	task runTxn(input logic [7:0] c, input logic [15:0] a, input logic [15:0] n);
		int i;
		startCmd = c;
		startAddr = a;
		startWords = n;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
		if (i == 20000) hang();
		repeat (4) @(negedge clk);
	endtask

	// queue n words base, base+1, ... into the fifo
	task pushN(input logic [15:0] base, input int n);
		int i;
		int j;
		wrValid = 1'b1;
		for (j = 0; j < n; j++) begin
			wrData = base + 16'(j);
			for (i = 0; i < 20000 && wrReady !== 1'b1; i++) @(negedge clk);
			if (i == 20000) hang();
			@(negedge clk);
		end
		wrValid = 1'b0;
	endtask

	// ===========================================================
	// main sequence
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		cmp16({16'h0000, link.miso}, 17'h00000);
		procRunning = 1'b0;
		repeat (8) @(negedge clk);
		cmp16({16'h0000, link.miso}, 17'h00001);
		pushN(16'hA000, 16);
		@(negedge clk);
		cmp16({16'h0000, wrReady}, 17'h00000);
		runTxn(CMD_WRITE, 16'h3A10, 16'h0010);
		cmpCnt(nWr, 16);
		for (k = 0; k < 16; k++) cmp16({1'b0, mem[8'h10 + k]}, {1'b0, 16'hA000 + 16'(k)});
		procRunning = 1'b1;
		// write with the fifo empty at start, so the serial clock stalls
		fork
			runTxn(CMD_WRITE, 16'h3A20, 16'h0003);
			begin
				// host is past the address by now and waits on the empty fifo
				repeat (700) @(negedge clk);
				cmp16({16'h0000, txnActive}, 17'h00001);
				cmp16({16'h0000, busy}, 17'h00001);
				pushN(16'h5000, 3);
			end
		join
		cmpCnt(nWr, 19);
		rdQ.delete();
		runTxn(CMD_READ, 16'h3A1F, 16'h0003);
		cmpCnt(rdQ.size(), 4);
		cmp16(rdQ[0], {1'b1, CMD_READ, 8'h3A});
		cmp16(rdQ[1], 17'h0A00F);
		cmp16(rdQ[2], 17'h05000);
		cmp16(rdQ[3], 17'h05001);
		rdQ.delete();
		runTxn(8'h00, 16'h3A10, 16'h0000);
		runTxn(8'h01, 16'h3A10, 16'h0000);
		runTxn(8'h04, 16'h3A10, 16'h0000);
		runTxn(8'hFF, 16'h3A10, 16'h0000);
		cmpCnt(nRej, 4);
		runTxn(CMD_WRITE, 16'h3A10, 16'h0000);
		cmpCnt(nWr, 19);
		cmpCnt(rdQ.size(), 0);
		cmp16({1'b0, mem[8'h10]}, 17'h0A000);
		cmpCnt(nAbort, 0);
		summarize();
	end

endmodule
